/* File: csft_pkg.sv */
package csft_pkg;
  // flag byte layout
  localparam int FLAG_C  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_S  = 5;
  localparam int FLAG_V  = 4;
  localparam int FLAG_D  = 3;
  localparam int FLAG_H  = 2;
  localparam int FLAG_U2 = 1;
  localparam int FLAG_U1 = 0;
  localparam logic [7:0] COND_MASK = 8'hFC;
  localparam logic [7:0] USER_MASK = 8'h03;
  localparam logic [7:0] COND_RST  = 8'h00;

  // register byte offsets on the bus
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_STACK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;

  // stack handling
  localparam logic [15:0] SP_RST    = 16'h0000;
  localparam logic [15:0] SP_STEP_PC = 16'h0002;
  localparam logic [15:0] SP_STEP_FL = 16'h0001;

  typedef enum logic [4:0] {
    OP_NOP   = 5'h00, OP_ADD   = 5'h01, OP_ADC   = 5'h02, OP_SUB  = 5'h03,
    OP_SBC   = 5'h04, OP_AND   = 5'h05, OP_OR    = 5'h06, OP_XOR  = 5'h07,
    OP_TM    = 5'h08, OP_TCM   = 5'h09, OP_COM   = 5'h0A, OP_RL   = 5'h0B,
    OP_RLC   = 5'h0C, OP_RR    = 5'h0D, OP_RRC   = 5'h0E, OP_SRA  = 5'h0F,
    OP_SRL   = 5'h10, OP_SWAP  = 5'h11, OP_RCF   = 5'h12, OP_SCF  = 5'h13,
    OP_CCF   = 5'h14, OP_SETU1 = 5'h15, OP_CLRU1 = 5'h16, OP_SETU2 = 5'h17,
    OP_CLRU2 = 5'h18
  } csft_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TPC  = 3'b001,
    ST_TFL  = 3'b010,
    ST_TVEC = 3'b011,
    ST_RFL  = 3'b100,
    ST_RPC  = 3'b101
  } csft_state_t;

  typedef enum logic [3:0] {
    CC_F   = 4'h0, CC_LT  = 4'h1, CC_LE  = 4'h2, CC_ULE = 4'h3,
    CC_OV  = 4'h4, CC_MI  = 4'h5, CC_Z   = 4'h6, CC_C   = 4'h7,
    CC_T   = 4'h8, CC_GE  = 4'h9, CC_GT  = 4'hA, CC_UGT = 4'hB,
    CC_NOV = 4'hC, CC_PL  = 4'hD, CC_NZ  = 4'hE, CC_NC  = 4'hF
  } csft_cc_t;
endpackage

/* File: csft_alu.sv */
`timescale 1ns/1ps
module csft_alu
(
  input  csft_pkg::csft_op_t op,
  input  logic [7:0]         dst,
  input  logic [7:0]         src,
  input  logic [7:0]         flags_in,
  output logic [7:0]         res,
  output logic               wr,
  output logic [7:0]         flags_out
);
  import csft_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;
  logic       cin;
  logic       zs;

  // flag datapath; flags not touched by an op keep flags_in
  always_comb
  begin
    cin       = flags_in[FLAG_C];
    sum       = 9'h000;
    nib       = 5'h00;
    res       = dst;
    wr        = 1'b0;
    zs        = 1'b1;
    flags_out = flags_in;
    case (op)
      OP_ADD, OP_ADC:
      begin
        sum = {1'b0, dst} + {1'b0, src} + {8'h00, (op == OP_ADC) && cin};
        nib = {1'b0, dst[3:0]} + {1'b0, src[3:0]} + {4'h0, (op == OP_ADC) && cin};
        res = sum[7:0];
        wr  = 1'b1;
        flags_out[FLAG_C] = sum[8];
        flags_out[FLAG_V] = (dst[7] == src[7]) && (sum[7] != dst[7]);
        flags_out[FLAG_D] = 1'b0;
        flags_out[FLAG_H] = nib[4];
      end
      OP_SUB, OP_SBC:
      begin
        sum = {1'b0, dst} - {1'b0, src} - {8'h00, (op == OP_SBC) && cin};
        nib = {1'b0, dst[3:0]} - {1'b0, src[3:0]} - {4'h0, (op == OP_SBC) && cin};
        res = sum[7:0];
        wr  = 1'b1;
        flags_out[FLAG_C] = sum[8]; // borrow
        flags_out[FLAG_V] = (dst[7] != src[7]) && (sum[7] != dst[7]);
        flags_out[FLAG_D] = 1'b1;
        flags_out[FLAG_H] = nib[4];
      end
      OP_AND, OP_OR, OP_XOR, OP_COM:
      begin
        if (op == OP_AND)
          res = dst & src;
        else if (op == OP_OR)
          res = dst | src;
        else if (op == OP_XOR)
          res = dst ^ src;
        else
          res = ~dst;
        wr = 1'b1;
        flags_out[FLAG_V] = 1'b0;
      end
      OP_TM, OP_TCM:
      begin
        // destination is only tested, never written
        res = (op == OP_TM) ? (dst & src) : (~dst & src);
        flags_out[FLAG_V] = 1'b0;
      end
      OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SRA, OP_SRL:
      begin
        if (op == OP_RL)
          res = {dst[6:0], dst[7]};
        else if (op == OP_RLC)
          res = {dst[6:0], cin};
        else if (op == OP_RR)
          res = {dst[0], dst[7:1]};
        else if (op == OP_RRC)
          res = {cin, dst[7:1]};
        else if (op == OP_SRA)
          res = {dst[7], dst[7:1]};
        else
          res = {1'b0, dst[7:1]};
        wr = 1'b1;
        flags_out[FLAG_C] = (op == OP_RL || op == OP_RLC) ? dst[7] : dst[0];
        flags_out[FLAG_V] = (op == OP_SRA) ? 1'b0 : (res[7] ^ dst[7]);
      end
      OP_SWAP:
      begin
        // carry and overflow are undefined here, so they simply hold
        res = {dst[3:0], dst[7:4]};
        wr  = 1'b1;
      end
      OP_RCF, OP_SCF, OP_CCF:
      begin
        zs = 1'b0;
        flags_out[FLAG_C] = (op == OP_SCF) ? 1'b1 : ((op == OP_CCF) ? ~cin : 1'b0);
      end
      OP_SETU1, OP_CLRU1, OP_SETU2, OP_CLRU2:
      begin
        // the only ops that may touch the user bits
        zs = 1'b0;
        if (op == OP_SETU1 || op == OP_CLRU1)
          flags_out[FLAG_U1] = (op == OP_SETU1);
        else
          flags_out[FLAG_U2] = (op == OP_SETU2);
      end
      default:
        zs = 1'b0;
    endcase
    if (zs)
    begin
      flags_out[FLAG_Z] = (res == 8'h00);
      flags_out[FLAG_S] = res[7];
    end
  end
endmodule

/* File: csft_top.sv */
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module csft_top
(
  input  logic                clk,
  input  logic                rstn,
  input  logic                ce,
  // ahb-lite slave
  input  logic                hsel,
  input  logic [31:0]         haddr,
  input  logic [1:0]          htrans,
  input  logic                hwrite,
  input  logic [2:0]          hsize,
  input  logic [31:0]         hwdata,
  input  logic                hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  // operation port
  input  logic                op_valid,
  input  csft_pkg::csft_op_t  op,
  input  logic [7:0]          op_dst,
  input  logic [7:0]          op_src,
  output logic [7:0]          dst_data,
  output logic                dst_we,
  // branch decode
  input  csft_pkg::csft_cc_t  cond_code,
  output logic                cond_true,
  output logic [7:0]          status_flags,
  // vector entry and return
  input  logic                entry_req,
  input  logic [15:0]         entry_pc,
  input  logic [15:0]         entry_vec_addr,
  input  logic                return_req,
  output logic                busy,
  output logic [15:0]         program_counter,
  output logic                pc_load,
  output logic [15:0]         stack_ptr,
  // stack memory port
  output logic                mem_req,
  output logic                mem_we,
  output logic                mem_word,
  output logic [15:0]         mem_addr,
  output logic [15:0]         mem_wdata,
  input  logic                mem_ack,
  input  logic [15:0]         mem_rdata
);
  import csft_pkg::*;

  logic [7:0]  cond_r;
  logic [7:0]  user_r;
  logic [7:0]  status;
  logic [7:0]  flags_nxt;
  logic [7:0]  alu_res;
  logic        alu_wr;
  logic [7:0]  alu_flags;
  csft_state_t st_r;
  logic [15:0] sp_r;
  logic [15:0] vec_r;
  logic        ap_take;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        rd_pend_r;
  logic [7:0]  rd_addr_r;
  logic        wr_flags;
  logic        wr_stack;
  logic        restore;
  logic        hreadyout_r;
  logic        hresp_r;
  logic [31:0] hrdata_r;
  logic        dst_we_r;
  logic [7:0]  dst_data_r;
  logic        cond_true_r;
  logic        pc_load_r;
  logic [15:0] pc_r;
  logic        mem_req_r;
  logic        mem_we_r;
  logic        mem_word_r;
  logic [15:0] mem_addr_r;
  logic [15:0] mem_wdata_r;

  // condition evaluator; user bits are not reachable from any code
  function automatic logic cond_eval(input csft_cc_t cc, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    c = f[FLAG_C];
    z = f[FLAG_Z];
    s = f[FLAG_S];
    v = f[FLAG_V];
    case (cc)
      CC_F:    cond_eval = 1'b0;
      CC_LT:   cond_eval = s ^ v;
      CC_LE:   cond_eval = z | (s ^ v);
      CC_ULE:  cond_eval = c | z;
      CC_OV:   cond_eval = v;
      CC_MI:   cond_eval = s;
      CC_Z:    cond_eval = z;
      CC_C:    cond_eval = c;
      CC_T:    cond_eval = 1'b1;
      CC_GE:   cond_eval = ~(s ^ v);
      CC_GT:   cond_eval = ~(z | (s ^ v));
      CC_UGT:  cond_eval = ~(c | z);
      CC_NOV:  cond_eval = ~v;
      CC_PL:   cond_eval = ~s;
      CC_NZ:   cond_eval = ~z;
      default: cond_eval = ~c;
    endcase
  endfunction

  csft_alu u_alu
  (
    .op        (op),
    .dst       (op_dst),
    .src       (op_src),
    .flags_in  (status),
    .res       (alu_res),
    .wr        (alu_wr),
    .flags_out (alu_flags)
  );

  assign status = {cond_r[7:2], user_r[1:0]};

  // bus decode: one wait state on reads, none on writes
  assign ap_take  = hsel && htrans[1] && hready;
  assign wr_flags = wr_pend_r && (wr_addr_r == ADDR_FLAGS);
  assign wr_stack = wr_pend_r && (wr_addr_r == ADDR_STACK);
  assign restore  = (st_r == ST_RFL) && mem_ack;

  // next flag byte: stack restore beats a bus write, which beats an op
  always_comb
  begin
    if (restore)
      flags_nxt = mem_rdata[7:0];
    else if (wr_flags)
      flags_nxt = hwdata[7:0];
    else if (op_valid)
      flags_nxt = alu_flags;
    else
      flags_nxt = status;
  end

  // condition bits, cleared by reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cond_r <= COND_RST;
    else if (ce)
      cond_r <= flags_nxt & COND_MASK;
  end

  // user bits carry no reset so they survive it untouched
  always_ff @(posedge clk)
  begin
    if (ce)
      user_r <= flags_nxt & USER_MASK;
  end

  // bus request capture
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_pend_r <= 1'b0;
      rd_addr_r <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend_r <= ap_take && hwrite;
      rd_pend_r <= ap_take && !hwrite;
      if (ap_take)
      begin
        wr_addr_r <= haddr[7:0];
        rd_addr_r <= haddr[7:0];
      end
    end
  end

  // read data is taken a cycle late so a preceding write is already visible
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      hrdata_r    <= 32'h00000000;
    end
    else if (ce)
    begin
      hresp_r     <= 1'b0;
      hreadyout_r <= !(ap_take && !hwrite);
      if (rd_pend_r)
      begin
        if (rd_addr_r == ADDR_FLAGS)
          hrdata_r <= {24'h000000, status};
        else if (rd_addr_r == ADDR_STACK)
          hrdata_r <= {16'h0000, sp_r};
        else if (rd_addr_r == ADDR_STATE)
          hrdata_r <= {28'h0000000, st_r != ST_IDLE, st_r};
        else
          hrdata_r <= 32'h00000000;
      end
    end
  end

  // destination writeback; mask tests never write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dst_we_r   <= 1'b0;
      dst_data_r <= 8'h00;
    end
    else if (ce)
    begin
      dst_we_r <= op_valid && alu_wr;
      if (op_valid && alu_wr)
        dst_data_r <= alu_res;
    end
  end

  // branch decision from the flags as they stand
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cond_true_r <= 1'b0;
    else if (ce)
      cond_true_r <= cond_eval(cond_code, status);
  end

  // entry and return sequencer; the flag byte is sampled as the pc push is acked,
  // so an op in that same cycle is pushed without its effect
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r        <= ST_IDLE;
      sp_r        <= SP_RST;
      vec_r       <= 16'h0000;
      pc_r        <= 16'h0000;
      pc_load_r   <= 1'b0;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_word_r  <= 1'b0;
      mem_addr_r  <= 16'h0000;
      mem_wdata_r <= 16'h0000;
    end
    else if (ce)
    begin
      pc_load_r <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (entry_req)
          begin
            sp_r        <= sp_r - SP_STEP_PC;
            vec_r       <= entry_vec_addr;
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b1;
            mem_word_r  <= 1'b1;
            mem_addr_r  <= sp_r - SP_STEP_PC;
            mem_wdata_r <= entry_pc;
            st_r        <= ST_TPC;
          end
          else if (return_req)
          begin
            mem_req_r  <= 1'b1;
            mem_we_r   <= 1'b0;
            mem_word_r <= 1'b0;
            mem_addr_r <= sp_r;
            st_r       <= ST_RFL;
          end
          else if (wr_stack)
            sp_r <= hwdata[15:0];
        end
        ST_TPC:
        begin
          if (mem_ack)
          begin
            sp_r        <= sp_r - SP_STEP_FL;
            mem_word_r  <= 1'b0;
            mem_addr_r  <= sp_r - SP_STEP_FL;
            mem_wdata_r <= {8'h00, status};
            st_r        <= ST_TFL;
          end
        end
        ST_TFL:
        begin
          if (mem_ack)
          begin
            mem_we_r   <= 1'b0;
            mem_word_r <= 1'b1;
            mem_addr_r <= vec_r;
            st_r       <= ST_TVEC;
          end
        end
        ST_TVEC:
        begin
          if (mem_ack)
          begin
            mem_req_r <= 1'b0;
            pc_r      <= mem_rdata;
            pc_load_r <= 1'b1;
            st_r      <= ST_IDLE;
          end
        end
        ST_RFL:
        begin
          if (mem_ack)
          begin
            sp_r       <= sp_r + SP_STEP_FL;
            mem_word_r <= 1'b1;
            mem_addr_r <= sp_r + SP_STEP_FL;
            st_r       <= ST_RPC;
          end
        end
        ST_RPC:
        begin
          if (mem_ack)
          begin
            sp_r      <= sp_r + SP_STEP_PC;
            mem_req_r <= 1'b0;
            pc_r      <= mem_rdata;
            pc_load_r <= 1'b1;
            st_r      <= ST_IDLE;
          end
        end
        default:
        begin
          mem_req_r <= 1'b0;
          st_r      <= ST_IDLE;
        end
      endcase
    end
  end

  // outputs straight from flops, except busy, which is decoded from st_r
  assign hreadyout       = hreadyout_r;
  assign hresp           = hresp_r;
  assign hrdata          = hrdata_r;
  assign dst_data        = dst_data_r;
  assign dst_we          = dst_we_r;
  assign cond_true       = cond_true_r;
  assign status_flags    = status;
  assign busy            = (st_r != ST_IDLE);
  assign program_counter = pc_r;
  assign pc_load         = pc_load_r;
  assign stack_ptr       = sp_r;
  assign mem_req         = mem_req_r;
  assign mem_we          = mem_we_r;
  assign mem_word        = mem_word_r;
  assign mem_addr        = mem_addr_r;
  assign mem_wdata       = mem_wdata_r;
endmodule

/* File: csft_top_properties.sv */
`timescale 1ns/1ps
module csft_top_properties
(
  input logic                clk,
  input logic                rstn,
  input logic                op_valid,
  input csft_pkg::csft_op_t  op,
  input logic [7:0]          op_dst,
  input logic [7:0]          op_src,
  input logic [7:0]          dst_data,
  input logic                dst_we,
  input csft_pkg::csft_cc_t  cond_code,
  input logic                cond_true,
  input logic [7:0]          status_flags,
  input logic                entry_req,
  input logic                busy,
  input logic [15:0]         program_counter,
  input logic                pc_load,
  input logic [15:0]         stack_ptr,
  input logic                mem_req,
  input logic                mem_we,
  input logic                mem_word,
  input logic [15:0]         mem_addr,
  input logic [15:0]         mem_wdata,
  input logic                mem_ack,
  input logic [15:0]         mem_rdata
);
  import csft_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // one acknowledged stack access of a given direction and size
  sequence s_ack(logic we, logic wd);
    mem_req && mem_ack && mem_we == we && mem_word == wd;
  endsequence
  property p_xor;
    op_valid && op == OP_XOR |=> dst_we && dst_data == ($past(op_dst) ^ $past(op_src))
      && status_flags[FLAG_Z] == (dst_data == 8'h00) && status_flags[FLAG_S] == dst_data[7]
      && !status_flags[FLAG_V] && status_flags[FLAG_C] == $past(status_flags[FLAG_C]);
  endproperty
  a_xor: assert property (p_xor) else $error("xor result or flags wrong");
  // mask tests never write back; zero follows the masked value
  property p_test;
    op_valid && (op == OP_TM || op == OP_TCM) |=> !dst_we && !status_flags[FLAG_V]
      && status_flags[FLAG_C] == $past(status_flags[FLAG_C])
      && status_flags[FLAG_Z] == ((($past(op) == OP_TM) ? ($past(op_dst) & $past(op_src))
      : (~$past(op_dst) & $past(op_src))) == 8'h00);
  endproperty
  a_test: assert property (p_test) else $error("mask test flags wrong");
  property p_user;
    op_valid && !busy && op inside {[OP_ADD:OP_CCF]} |=> status_flags[1:0] == $past(status_flags[1:0]);
  endproperty
  a_user: assert property (p_user) else $error("user bits changed by arithmetic");
  property p_cc_z;
    cond_code == CC_Z |=> cond_true == $past(status_flags[FLAG_Z]);
  endproperty
  a_cc_z: assert property (p_cc_z) else $error("zero condition wrong");
  property p_cc_c;
    cond_code == CC_C |=> cond_true == $past(status_flags[FLAG_C]);
  endproperty
  a_cc_c: assert property (p_cc_c) else $error("carry condition wrong");
  property p_entry;
    !busy && entry_req |=> busy && mem_req && mem_we && mem_word
      && stack_ptr == $past(stack_ptr) - SP_STEP_PC && mem_addr == stack_ptr;
  endproperty
  a_entry: assert property (p_entry) else $error("entry pc push wrong");
  // flag byte push follows the pc push at the next address down
  property p_push_fl;
    s_ack(1'b1, 1'b1) |=> mem_req && mem_we && !mem_word && mem_addr == stack_ptr
      && stack_ptr == $past(stack_ptr) - SP_STEP_FL && mem_wdata[7:0] == $past(status_flags);
  endproperty
  a_push_fl: assert property (p_push_fl) else $error("flag push wrong");
  property p_restore;
    s_ack(1'b0, 1'b0) |=> status_flags == $past(mem_rdata[7:0]);
  endproperty
  a_restore: assert property (p_restore) else $error("flag restore wrong");
  property p_pc;
    s_ack(1'b0, 1'b1) |=> pc_load && program_counter == $past(mem_rdata);
  endproperty
  a_pc: assert property (p_pc) else $error("pc load wrong");
endmodule

/* File: csft_top_tb.sv */
`timescale 1ns/1ps
module csft_top_tb;
  import csft_pkg::*;
  logic        clk, rstn, hsel, hwrite, op_valid, entry_req, return_req, mem_ack;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [7:0]  op_dst, op_src, dst_data, status_flags;
  logic [15:0] entry_pc, entry_vec_addr, mem_rdata, program_counter, stack_ptr, mem_addr, mem_wdata;
  logic        hready, hreadyout, hresp, dst_we, cond_true, busy, pc_load, mem_req, mem_we, mem_word;
  csft_op_t    op;
  csft_cc_t    cond_code;
  int          err_total, compares, cyc;
  // expected outcome of codes 0..15 while c=1 z=1 s=0 v=0
  localparam logic [15:0] CC_EXP = 16'h33CC;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  csft_top DUT (.clk(clk), .rstn(rstn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .op_valid(op_valid), .op(op), .op_dst(op_dst), .op_src(op_src),
    .dst_data(dst_data), .dst_we(dst_we), .cond_code(cond_code), .cond_true(cond_true),
    .status_flags(status_flags), .entry_req(entry_req), .entry_pc(entry_pc),
    .entry_vec_addr(entry_vec_addr), .return_req(return_req), .busy(busy),
    .program_counter(program_counter), .pc_load(pc_load), .stack_ptr(stack_ptr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ready and read data are sampled at the rising edge, before the flops move
  task automatic wait_rdy;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    wait_rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= w ? d : 32'h0;
    wait_rdy;
  endtask
  task automatic run_op(csft_op_t o, logic [7:0] d, logic [7:0] s);
    @(posedge clk);
    op_valid <= 1'b1; op <= o; op_dst <= d; op_src <= s;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask
  // stack memory stand-in: checks the request, then acks once
  task automatic mem_srv(logic [15:0] a, logic we, logic w, logic [15:0] wd, logic [15:0] rd);
    do begin @(posedge clk); #1; end while (mem_req !== 1'b1);
    chk("mem_addr", a, mem_addr);
    chk("mem_dir", {we, w}, {mem_we, mem_word});
    if (we)
      chk("mem_wdata", w ? wd : wd[7:0], w ? mem_wdata : mem_wdata[7:0]);
    @(posedge clk);
    mem_ack <= 1'b1; mem_rdata <= rd;
    @(posedge clk);
    mem_ack <= 1'b0; mem_rdata <= ~rd;
  endtask
  task automatic wait_idle;
    do begin @(posedge clk); #1; end while (busy !== 1'b0);
  endtask
  // hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      complete_run;
    end
  end
  always #25 clk = ~clk;
  initial
  begin
    clk = 0; rstn = 0; err_total = 0; compares = 0; cyc = 0;
    {hsel, hwrite, op_valid, entry_req, return_req, mem_ack} = '0;
    {haddr, hwdata, htrans, op_dst, op_src, entry_pc, entry_vec_addr, mem_rdata} = '0;
    op = OP_NOP; cond_code = CC_F;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("busy", 0, busy);
    chk("stack_ptr", SP_RST, stack_ptr);
    chk("cond_bits", COND_RST, status_flags & COND_MASK);
    chk("bus_idle", 2'b10, {hreadyout, hresp});
    $display("test reset done");
    @(posedge clk);
    ahb(1'b1, ADDR_FLAGS, 32'h03);
    ahb(1'b0, ADDR_FLAGS, 0);
    chk("flags_rd", 32'h03, rdv);
    ahb(1'b0, 32'h0C, 0);
    chk("unmapped_rd", 32'h0, rdv);
    ahb(1'b1, ADDR_STACK, 32'h0100);
    ahb(1'b0, ADDR_STACK, 0);
    chk("stack_rd", 32'h0100, rdv);
    ahb(1'b0, ADDR_STATE, 0);
    chk("state_rd", 32'h0, rdv);
    $display("test registers done");
    cond_code <= CC_C;
    run_op(OP_SCF, 8'h00, 8'h00);
    chk("scf_flags", 8'h83, status_flags);
    run_op(OP_XOR, 8'h0F, 8'hFF);
    chk("xor_res", {1'b1, 8'hF0}, {dst_we, dst_data});
    chk("xor_flags", 8'hA3, status_flags);
    chk("cc_carry", 1'b1, cond_true);
    run_op(OP_XOR, 8'h5A, 8'h5A);
    chk("xor_zero", 8'hC3, status_flags);
    run_op(OP_TM, 8'h80, 8'h80);
    chk("tm_flags", {1'b0, 8'hA3}, {dst_we, status_flags});
    run_op(OP_TCM, 8'hFF, 8'h0F);
    chk("tcm_flags", {1'b0, 8'hC3}, {dst_we, status_flags});
    run_op(OP_ADD, 8'hFF, 8'h01);
    chk("add_res", {1'b1, 8'h00}, {dst_we, dst_data});
    chk("add_flags", 8'hC7, status_flags);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      cond_code <= csft_cc_t'(i);
      repeat (2) @(posedge clk);
      #1;
      chk("cond", CC_EXP[i], cond_true);
    end
    $display("test flags done");
    @(posedge clk);
    entry_req <= 1'b1; entry_pc <= 16'h1234; entry_vec_addr <= 16'h0040;
    @(posedge clk);
    entry_req <= 1'b0;
    mem_srv(16'h00FE, 1'b1, 1'b1, 16'h1234, 16'h0000);
    mem_srv(16'h00FD, 1'b1, 1'b0, 16'h00C7, 16'h0000);
    mem_srv(16'h0040, 1'b0, 1'b1, 16'h0000, 16'h2000);
    wait_idle;
    chk("trap_pc", 16'h2000, program_counter);
    chk("trap_sp", 16'h00FD, stack_ptr);
    chk("trap_flags", 8'hC7, status_flags);
    @(posedge clk);
    ahb(1'b1, ADDR_FLAGS, 32'h00);
    return_req <= 1'b1;
    @(posedge clk);
    return_req <= 1'b0;
    mem_srv(16'h00FD, 1'b0, 1'b0, 16'h0000, 16'h005A);
    mem_srv(16'h00FE, 1'b0, 1'b1, 16'h0000, 16'h1234);
    wait_idle;
    chk("interrupt_return_op_flags", 8'h5A, status_flags);
    chk("interrupt_return_op_pc", 16'h1234, program_counter);
    chk("interrupt_return_op_sp", 16'h0100, stack_ptr);
    $display("test trap and return done");
    run_op(OP_SUB, 8'h00, 8'h01);
    chk("sub_res", {1'b1, 8'hFF}, {dst_we, dst_data});
    chk("sub_flags", 8'hAE, status_flags);
    run_op(OP_SETU1, 8'h00, 8'h00);
    chk("setu1_flags", {1'b0, 8'hAF}, {dst_we, status_flags});
    run_op(OP_CLRU2, 8'h00, 8'h00);
    chk("clru2_flags", 8'hAD, status_flags);
    $display("test user bits done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("user_kept", 8'h01, status_flags);
    $display("test second reset done");
    complete_run;
  end
endmodule
bind csft_top csft_top_properties u_props (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op(op),
  .op_dst(op_dst), .op_src(op_src), .dst_data(dst_data), .dst_we(dst_we), .cond_code(cond_code),
  .cond_true(cond_true), .status_flags(status_flags), .entry_req(entry_req), .busy(busy),
  .program_counter(program_counter), .pc_load(pc_load), .stack_ptr(stack_ptr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata));
